// ---- hw/bsu_pkg.sv ----
package bsu_pkg;
  localparam int QUEUE_DEPTH = 6;
  localparam int RESET_SEQ_CYCLES = 10;
  localparam logic [15:0] RESET_CODE_SEG = 16'hFFFF;
  localparam logic [15:0] RESET_CODE_OFF = 16'h0000;
  localparam logic [7:0] NMI_TYPE = 8'h02;
  localparam logic [3:0] SEG_LOW_NIBBLE = 4'h0;
  localparam logic [3:0] PORT_UPPER_ADDR = 4'h0;
  localparam logic [1:0] VEC_LOW_BITS = 2'b00;
  localparam logic [9:0] VEC_HIGH_BITS = 10'h000;

  typedef enum logic [2:0] {
    CYC_INTACK = 3'b000,
    CYC_PORT_READ = 3'b001,
    CYC_PORT_WRITE = 3'b010,
    CYC_HALT = 3'b011,
    CYC_FETCH = 3'b100,
    CYC_MEM_READ = 3'b101,
    CYC_MEM_WRITE = 3'b110,
    CYC_PASSIVE = 3'b111
  } bsu_cyc_t;

  typedef enum logic [1:0] {
    SEG_EXTRA = 2'b00,
    SEG_STACK = 2'b01,
    SEG_CODE = 2'b10,
    SEG_DATA = 2'b11
  } bsu_seg_t;

  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_HALT} bsu_state_t;
  typedef enum logic [1:0] {SRC_FETCH, SRC_EU, SRC_ACK, SRC_HALT} bsu_src_t;

  typedef struct packed {
    bsu_cyc_t kind;
    bsu_seg_t seg;
    logic [15:0] segBase;
    logic [15:0] offset;
    logic word;
    logic [15:0] wdata;
  } bsu_eureq_t;

  typedef struct packed {
    bsu_cyc_t kind;
    bsu_seg_t seg;
    logic [19:0] addr;
    logic upper;
    logic lower;
    logic [15:0] wdata;
  } bsu_acc_t;

  typedef struct packed {
    logic [3:0] upperAddressLines;
    logic upperByteEnableN;
    logic ale;
    logic rdN;
    logic wrN;
    logic irqAckStrobeN;
    logic memIoSel;
    logic xmitRecv;
    logic dataEnableN;
    logic lockN;
    bsu_cyc_t cycleTypeStatus;
  } bsu_ctl_t;
endpackage : bsu_pkg

// ---- hw/bsu_prefetch_queue.sv ----
`timescale 1ns/1ps
module bsu_prefetch_queue #(
  parameter int DEPTH = bsu_pkg::QUEUE_DEPTH
) (
  input wire logic clk, // clock
  input wire logic rstn, // async reset, active low
  input wire logic flush, // empty the queue
  input wire logic [1:0] pushCnt, // bytes pushed this cycle, 0..2
  input wire logic [15:0] pushData, // low byte goes in first
  input wire logic popReq, // take one byte
  output logic qValid, // queue holds a byte
  output logic [7:0] qByte, // oldest byte
  output logic [2:0] freeCnt // free entries
);
  import bsu_pkg::*;

  logic [7:0] mem [DEPTH];
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic pop;
  logic [2:0] base;

  assign qValid = count_reg != 3'd0;
  assign qByte = mem[0];
  assign freeCnt = 3'(DEPTH) - count_reg;
  assign pop = popReq & qValid;
  assign base = count_reg - {2'b00, pop};
  assign count_next = flush ? 3'd0 : base + {1'b0, pushCnt};

  // entries shift toward the head on a pop, new bytes land behind the survivors
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : gEntry
      logic [7:0] shifted;
      if (i == DEPTH - 1) begin : gLast
        assign shifted = pop ? 8'h00 : mem[i];
      end else begin : gMid
        assign shifted = pop ? mem[i + 1] : mem[i];
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          mem[i] <= 8'h00;
        end else if (!flush && pushCnt != 2'd0 && base == 3'(i)) begin
          mem[i] <= pushData[7:0];
        end else if (!flush && pushCnt == 2'd2 && base + 3'd1 == 3'(i)) begin
          mem[i] <= pushData[15:8];
        end else begin
          mem[i] <= shifted;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 3'd0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : bsu_prefetch_queue

// ---- hw/bsu_irq_ctrl.sv ----
`timescale 1ns/1ps
module bsu_irq_ctrl (
  input wire logic clk, // clock
  input wire logic rstn, // async reset, active low
  input wire logic abort, // device reset pin high or reset sequence running
  input wire logic nmi, // unmaskable request
  input wire logic maskableIrq, // level request
  input wire logic ifFlag, // interrupt enable flag
  input wire logic boundary, // instruction or string-step end
  input wire logic halted, // bus unit halted
  input wire logic ackDone, // second acknowledge finished
  input wire logic [7:0] ackType, // type byte from second acknowledge
  output logic startAck, // begin acknowledge pair (pulse)
  output logic take, // interrupt taken (pulse)
  output logic [7:0] takeType // type of the taken interrupt
);
  import bsu_pkg::*;

  logic nmiPrev_reg;
  logic nmiSeen_reg;
  logic nmiPend_reg;
  logic ackBusy_reg;
  logic nmiSet;
  logic window;
  logic nmiTake;

  // a request counts after two high samples, once per pulse
  assign nmiSet = nmi & nmiPrev_reg & !nmiSeen_reg;
  assign window = (boundary | halted) & !abort;
  assign nmiTake = window & nmiPend_reg & !ackBusy_reg;
  assign startAck = window & !nmiPend_reg & maskableIrq & ifFlag & !ackBusy_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmiPrev_reg <= 1'b0;
      nmiSeen_reg <= 1'b0;
      nmiPend_reg <= 1'b0;
      ackBusy_reg <= 1'b0;
      take <= 1'b0;
      takeType <= 8'h00;
    end else begin
      nmiPrev_reg <= nmi;
      nmiSeen_reg <= nmi & (nmiSeen_reg | nmiPrev_reg);
      nmiPend_reg <= !abort & (nmiSet | (nmiPend_reg & !nmiTake));
      ackBusy_reg <= !abort & (startAck | (ackBusy_reg & !ackDone));
      take <= nmiTake | ackDone;
      takeType <= nmiTake ? NMI_TYPE : ackType;
    end
  end
endmodule : bsu_irq_ctrl

// ---- hw/bsu_bus_unit.sv ----
`timescale 1ns/1ps
// What this block does
// - all state sits in static flops, so the clock may stop at any level
// - each bus cycle runs T1, T2, T3, T4 in order, at least four states
// - address driven in T1, T2 turns reads around, data moves in T3/T4
// - not-ready inserts wait states between T3 and T4 until ready
// - address latch strobe pulses high in T1, from this block in minimum mode
// - cycle type status encodes acknowledge, ports, halt, fetch, memory, passive
// - upper address pins carry status from T2 through T4; byte-enable pin stays byte enable T1 through T4
// - segment status reports the segment used; another bit mirrors interrupt enable
// - port cycles put 16-bit port address low and upper address lines low
// - 20-bit byte addresses; even bytes low lane, odd high; odd words split
// - prefetch up to six instruction bytes while the execute unit runs
// - physical address is segment base times sixteen plus offset
// - reset rise aborts; fall starts ten-clock sequence, then fetch at FFFF0
// - unmaskable beats maskable; both taken only at instruction or string-step ends or while halted
// - taking an interrupt pulses irqClearIf so the execute unit clears the enable flag and pushes flags
// - two acknowledge cycles; lock from first T2 to second T2, others blocked
// - second acknowledge reads type byte; pointer address is type times four
// - halt instruction halts until an interrupt or reset
// - minimum-mode strobes active from T2 start to T4 start; space select T1-T4
// - ready is sampled at the end of T3 and each wait state
// - mode pin high makes own strobes; low leaves them to an outside controller
module bsu_bus_unit #(
  parameter int RESET_CYCLES = bsu_pkg::RESET_SEQ_CYCLES
) (
  input wire logic clk, // clock, may stop
  input wire logic rstn, // async reset, active low
  input wire logic cpuReset, // device reset pin, active high
  input wire logic modeSelectPin, // high: minimum mode
  input wire logic ready, // addressed device ready
  input wire logic [15:0] muxedBusLinesIn, // shared bus, sampled
  output logic [15:0] muxedBusLinesOut, // shared bus, driven value
  output logic muxedBusLinesOen, // low while driving the shared bus
  output bsu_pkg::bsu_ctl_t ctlPins, // address, status and strobe pins
  input wire logic euReqValid, // execute unit request held until done
  input wire bsu_pkg::bsu_eureq_t euReq, // execute unit request
  output logic euDone, // request finished (pulse)
  output logic [15:0] euRdata, // read result
  input wire logic qPop, // execute unit takes a byte
  output logic qValid, // instruction byte available
  output logic [7:0] qByte, // next instruction byte
  input wire logic flushValid, // restart prefetch at new address
  input wire logic [15:0] flushSeg, // new code segment
  input wire logic [15:0] flushOff, // new instruction offset
  input wire logic instrBoundary, // instruction or string step ends
  input wire logic ifFlag, // interrupt enable flag
  input wire logic nmi, // unmaskable request
  input wire logic maskableIrq, // maskable request level
  output logic irqTake, // interrupt taken (pulse)
  output logic [7:0] irqType, // taken interrupt type
  output logic [19:0] irqVector, // pointer table address
  output logic irqClearIf, // execute unit clears enable and pushes flags
  output logic haltedOut, // in halt state
  output logic resetBusy // reset sequence running
);
  import bsu_pkg::*;

  bsu_state_t st_reg, st_next;
  bsu_src_t src_reg, src_next;
  bsu_acc_t acc_reg, acc_next, accPick;
  bsu_ctl_t ctl_next;
  logic [3:0] resetCnt_reg;
  logic [15:0] fetchSeg_reg, fetchOff_reg;
  logic discard_reg, euPhase_reg, ackCnt_reg, ackPend_reg, lock_reg, lock_next;
  logic halted_reg, euLow_reg, ackDone;
  logic [7:0] euLowByte_reg;
  logic [15:0] busOut_next;
  logic busOen_next;
  logic [2:0] freeCnt;
  logic [1:0] pushCnt;
  logic [15:0] pushData;
  logic startAck;

  // decode of the pending work and the access it would make
  wire seqBusy = cpuReset | (resetCnt_reg != 4'd0);
  wire atEnd = st_reg == ST_IDLE || st_reg == ST_T4 || st_reg == ST_HALT;
  wire xferDone = (st_reg == ST_T3 || st_reg == ST_TW) && ready;
  wire euIsIo = euReq.kind == CYC_PORT_READ || euReq.kind == CYC_PORT_WRITE;
  wire [19:0] euPhys = {euReq.segBase, SEG_LOW_NIBBLE} + {PORT_UPPER_ADDR, euReq.offset};
  wire [19:0] euBase = euIsIo ? {PORT_UPPER_ADDR, euReq.offset} : euPhys;
  wire [19:0] euAddr = euBase + {19'h00000, euPhase_reg};
  wire euSplit = euReq.word & euBase[0];
  wire [19:0] fetchPhys = {fetchSeg_reg, SEG_LOW_NIBBLE} + {PORT_UPPER_ADDR, fetchOff_reg};
  wire pickAck = ackPend_reg & !seqBusy;
  wire pickEu = euReqValid & !euDone & !seqBusy & !halted_reg;
  wire pickFetch = !seqBusy & !halted_reg & !flushValid & (freeCnt >= 3'd2);
  wire anyPick = pickAck | pickEu | pickFetch;
  wire wake = irqTake | startAck | pickAck;
  wire isWrite = acc_reg.kind == CYC_PORT_WRITE || acc_reg.kind == CYC_MEM_WRITE;
  wire euLast = !euSplit | euPhase_reg;

  always_comb begin
    accPick = '0;
    src_next = SRC_FETCH;
    if (pickAck) begin
      src_next = SRC_ACK;
      accPick.kind = CYC_INTACK;
      accPick.seg = SEG_CODE;
      accPick.lower = 1'b1;
    end else if (pickEu) begin
      src_next = euReq.kind == CYC_HALT ? SRC_HALT : SRC_EU;
      accPick.kind = euReq.kind;
      accPick.seg = euReq.seg;
      accPick.addr = euAddr;
      // a split word moves its low byte on the odd lane, then the high byte
      accPick.upper = euReq.word ? (!euSplit | !euPhase_reg) : euAddr[0];
      accPick.lower = euReq.word ? (!euSplit | euPhase_reg) : !euAddr[0];
      if (!euReq.word || euSplit) begin
        accPick.wdata = euPhase_reg ? {2{euReq.wdata[15:8]}} : {2{euReq.wdata[7:0]}};
      end else begin
        accPick.wdata = euReq.wdata;
      end
    end else begin
      accPick.kind = CYC_FETCH;
      accPick.seg = SEG_CODE;
      accPick.addr = fetchPhys;
      accPick.upper = 1'b1;
      accPick.lower = !fetchPhys[0];
    end
  end

  // states advance T1, T2, T3, optional waits, T4
  always_comb begin
    st_next = st_reg;
    acc_next = acc_reg;
    case (st_reg)
      ST_IDLE, ST_T4: begin
        if (st_reg == ST_T4 && src_reg == SRC_HALT) begin
          st_next = ST_HALT;
        end else if (anyPick) begin
          st_next = ST_T1;
          acc_next = accPick;
        end else begin
          st_next = ST_IDLE;
        end
      end
      ST_HALT: st_next = wake ? ST_IDLE : ST_HALT;
      ST_T1: st_next = ST_T2;
      ST_T2: st_next = ST_T3;
      ST_T3, ST_TW: st_next = ready ? ST_T4 : ST_TW;
      default: st_next = ST_IDLE;
    endcase
    if (cpuReset) begin
      st_next = ST_IDLE;
    end
  end

  // pins are computed for the coming state and registered
  wire stActive = st_next inside {ST_T1, ST_T2, ST_T3, ST_TW, ST_T4};
  wire stStrobe = st_next inside {ST_T2, ST_T3, ST_TW};
  wire nIsWrite = acc_next.kind == CYC_PORT_WRITE || acc_next.kind == CYC_MEM_WRITE;
  wire nIsRead = acc_next.kind inside {CYC_FETCH, CYC_MEM_READ, CYC_PORT_READ};
  wire nIsAck = acc_next.kind == CYC_INTACK;

  assign lock_next = cpuReset ? 1'b0 :
    (st_next == ST_T2 && st_reg == ST_T1 && src_reg == SRC_ACK) ? !ackCnt_reg : lock_reg;

  always_comb begin
    ctl_next.upperAddressLines = PORT_UPPER_ADDR;
    ctl_next.upperByteEnableN = 1'b1;
    ctl_next.ale = 1'b0;
    ctl_next.rdN = 1'b1;
    ctl_next.wrN = 1'b1;
    ctl_next.irqAckStrobeN = 1'b1;
    ctl_next.memIoSel = 1'b0;
    ctl_next.xmitRecv = 1'b0;
    ctl_next.dataEnableN = 1'b1;
    ctl_next.lockN = !lock_next;
    ctl_next.cycleTypeStatus = CYC_PASSIVE;
    busOut_next = 16'h0000;
    busOen_next = 1'b1;
    if (stActive) begin
      ctl_next.upperByteEnableN = !acc_next.upper;
      ctl_next.memIoSel = acc_next.kind[2] & modeSelectPin;
      ctl_next.xmitRecv = nIsWrite;
      if (st_next != ST_T4) begin
        ctl_next.cycleTypeStatus = acc_next.kind;
      end
      if (st_next == ST_T1) begin
        ctl_next.upperAddressLines = acc_next.addr[19:16];
        ctl_next.ale = modeSelectPin;
        busOut_next = acc_next.addr[15:0];
        busOen_next = nIsAck;
      end else begin
        ctl_next.upperAddressLines = {1'b0, ifFlag, acc_next.seg};
        busOut_next = acc_next.wdata;
        busOen_next = !nIsWrite;
        ctl_next.dataEnableN = !(modeSelectPin & (nIsWrite | nIsRead | nIsAck));
      end
      if (stStrobe && modeSelectPin) begin
        ctl_next.rdN = !nIsRead;
        ctl_next.wrN = !nIsWrite;
        ctl_next.irqAckStrobeN = !nIsAck;
      end
    end
  end

  // prefetched bytes enter the queue unless a flush overtook the fetch
  wire fetchLand = xferDone && src_reg == SRC_FETCH && !discard_reg && !flushValid && !cpuReset;
  assign pushCnt = fetchLand ? (acc_reg.lower ? 2'd2 : 2'd1) : 2'd0;
  assign pushData = acc_reg.lower ? muxedBusLinesIn : {8'h00, muxedBusLinesIn[15:8]};
  assign ackDone = xferDone && src_reg == SRC_ACK && ackCnt_reg;
  assign irqVector = {VEC_HIGH_BITS, irqType, VEC_LOW_BITS};
  assign irqClearIf = irqTake;
  assign haltedOut = halted_reg;
  assign resetBusy = seqBusy;

  bsu_prefetch_queue #(
    .DEPTH(QUEUE_DEPTH)
  ) uQueue (
    .clk(clk),
    .rstn(rstn),
    .flush(flushValid | cpuReset),
    .pushCnt(pushCnt),
    .pushData(pushData),
    .popReq(qPop),
    .qValid(qValid),
    .qByte(qByte),
    .freeCnt(freeCnt)
  );

  bsu_irq_ctrl uIrq (
    .clk(clk),
    .rstn(rstn),
    .abort(seqBusy),
    .nmi(nmi),
    .maskableIrq(maskableIrq),
    .ifFlag(ifFlag),
    .boundary(instrBoundary),
    .halted(halted_reg),
    .ackDone(ackDone),
    .ackType(muxedBusLinesIn[7:0]),
    .startAck(startAck),
    .take(irqTake),
    .takeType(irqType)
  );

  // every register below is a static flop; a stopped clock just freezes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_IDLE;
      src_reg <= SRC_FETCH;
      acc_reg <= '0;
      // idle pin levels: strobes high, no latch pulse, status passive
      ctlPins <= '{upperAddressLines: PORT_UPPER_ADDR, upperByteEnableN: 1'b1, ale: 1'b0,
        rdN: 1'b1, wrN: 1'b1, irqAckStrobeN: 1'b1, memIoSel: 1'b0, xmitRecv: 1'b0,
        dataEnableN: 1'b1, lockN: 1'b1, cycleTypeStatus: CYC_PASSIVE};
      muxedBusLinesOut <= 16'h0000;
      muxedBusLinesOen <= 1'b1;
      lock_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      src_reg <= (atEnd && anyPick) ? src_next : src_reg;
      acc_reg <= acc_next;
      ctlPins <= ctl_next;
      muxedBusLinesOut <= busOut_next;
      muxedBusLinesOen <= busOen_next;
      lock_reg <= lock_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resetCnt_reg <= 4'd0;
      fetchSeg_reg <= RESET_CODE_SEG;
      fetchOff_reg <= RESET_CODE_OFF;
    end else if (cpuReset) begin
      resetCnt_reg <= 4'(RESET_CYCLES);
      fetchSeg_reg <= RESET_CODE_SEG;
      fetchOff_reg <= RESET_CODE_OFF;
    end else begin
      resetCnt_reg <= resetCnt_reg - {3'b000, resetCnt_reg != 4'd0};
      if (flushValid) begin
        fetchSeg_reg <= flushSeg;
        fetchOff_reg <= flushOff;
      end else if (fetchLand) begin
        fetchOff_reg <= fetchOff_reg + {14'h0000, pushCnt};
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      discard_reg <= 1'b0;
      euPhase_reg <= 1'b0;
      euDone <= 1'b0;
      euRdata <= 16'h0000;
      euLowByte_reg <= 8'h00;
      ackCnt_reg <= 1'b0;
      ackPend_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else if (cpuReset) begin
      discard_reg <= 1'b0;
      euPhase_reg <= 1'b0;
      euDone <= 1'b0;
      ackCnt_reg <= 1'b0;
      ackPend_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      if (st_next == ST_T1) begin
        discard_reg <= 1'b0;
      end else if (flushValid && src_reg == SRC_FETCH && !atEnd) begin
        discard_reg <= 1'b1;
      end
      euDone <= 1'b0;
      if (xferDone && (src_reg == SRC_EU || src_reg == SRC_HALT)) begin
        euPhase_reg <= !euLast;
        euDone <= euLast;
        if (!euLast) begin
          euLowByte_reg <= muxedBusLinesIn[15:8];
        end else if (euSplit) begin
          euRdata <= {muxedBusLinesIn[7:0], euLowByte_reg};
        end else if (!euReq.word) begin
          euRdata <= {8'h00, acc_reg.upper ? muxedBusLinesIn[15:8] : muxedBusLinesIn[7:0]};
        end else begin
          euRdata <= muxedBusLinesIn;
        end
      end
      if (xferDone && src_reg == SRC_ACK) begin
        ackCnt_reg <= !ackCnt_reg;
      end
      ackPend_reg <= startAck | (ackPend_reg & !(atEnd && pickAck && ackCnt_reg));
      if (st_reg == ST_T4 && src_reg == SRC_HALT) begin
        halted_reg <= 1'b1;
      end else if (wake) begin
        halted_reg <= 1'b0;
      end
    end
  end
endmodule : bsu_bus_unit

// ---- testbench/bsu_bus_unit_asserts.sv ----
`timescale 1ns/1ps
module bsu_bus_unit_asserts (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic ready, // ready input
  input wire logic resetBusy, // reset sequence
  input wire logic muxedBusLinesOen, // bus enable
  input wire bsu_pkg::bsu_ctl_t ctlPins, // pins
  input wire logic irqTake, // taken pulse
  input wire logic [7:0] irqType, // taken type
  input wire logic [19:0] irqVector // pointer address
);
  import bsu_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rd_t1;
    ctlPins.ale && ctlPins.cycleTypeStatus == CYC_MEM_READ;
  endsequence
  sequence s_rd_t3(bit rdy);
    s_rd_t1 ##2 ready == rdy;
  endsequence
  property p_four_states;
    ctlPins.ale |=> !ctlPins.ale [*3];
  endproperty
  a_four_states: assert property (p_four_states) else $error("bus cycle too short");
  property p_rd_t2;
    s_rd_t1 |=> !ctlPins.rdN && ctlPins.memIoSel;
  endproperty
  a_rd_t2: assert property (p_rd_t2) else $error("read strobe late");
  property p_wait;
    s_rd_t3(1'b0) |=> !ctlPins.rdN;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state missing");
  property p_t4;
    s_rd_t3(1'b1) |=> ctlPins.rdN && ctlPins.cycleTypeStatus == CYC_PASSIVE;
  endproperty
  a_t4: assert property (p_t4) else $error("T4 not entered");
  property p_port_upper;
    ctlPins.ale && ctlPins.cycleTypeStatus inside {CYC_PORT_READ, CYC_PORT_WRITE}
      |-> ctlPins.upperAddressLines == 4'h0;
  endproperty
  a_port_upper: assert property (p_port_upper) else $error("port upper lines set");
  property p_status;
    ctlPins.ale |=> ctlPins.upperAddressLines[3] == 1'b0 && $stable(ctlPins.cycleTypeStatus);
  endproperty
  a_status: assert property (p_status) else $error("status wrong in T2");
  property p_lock;
    $fell(ctlPins.lockN) |-> !ctlPins.irqAckStrobeN ##1 !ctlPins.lockN [*3];
  endproperty
  a_lock: assert property (p_lock) else $error("lock span short");
  property p_ack_float;
    !ctlPins.irqAckStrobeN |-> muxedBusLinesOen;
  endproperty
  a_ack_float: assert property (p_ack_float) else $error("bus driven in ack");
  property p_vector;
    irqTake |-> irqVector == {10'h000, irqType, 2'b00};
  endproperty
  a_vector: assert property (p_vector) else $error("pointer address wrong");
  property p_reset_quiet;
    resetBusy && $past(resetBusy) |-> !ctlPins.ale;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("cycle during reset");
endmodule : bsu_bus_unit_asserts

bind bsu_bus_unit bsu_bus_unit_asserts u_asserts (.clk(clk), .rstn(rstn), .ready(ready),
  .resetBusy(resetBusy), .muxedBusLinesOen(muxedBusLinesOen), .ctlPins(ctlPins),
  .irqTake(irqTake), .irqType(irqType), .irqVector(irqVector));

// ---- testbench/bsu_mem_model.sv ----
`timescale 1ns/1ps
module bsu_mem_model (
  input wire logic clk, // clock
  input wire bsu_pkg::bsu_ctl_t ctlPins, // device pins
  input wire logic [15:0] busOut, // device bus value
  input wire logic busOen, // low while device drives
  input wire logic [2:0] waitMax, // wait depth per cycle
  input wire logic [7:0] vecType, // type byte handed back
  output logic [15:0] busIn, // resolved bus
  output logic ready // ready to the device
);
  import bsu_pkg::*;
  logic [19:0] addr = 20'h00000;
  logic [15:0] lastBus = 16'h0000;
  logic [2:0] waitCnt = 3'h0;
  wire logic strobe = !ctlPins.rdN || !ctlPins.irqAckStrobeN;
  function automatic logic [7:0] memByte(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : memByte
  // a released bus with no read or acknowledge strobe shows a changing pattern, never the last value
  assign busIn = !busOen ? busOut : !strobe ? ~lastBus :
    !ctlPins.irqAckStrobeN ? {~lastBus[15:8], ctlPins.lockN ? vecType : ~lastBus[7:0]} :
    {memByte(addr | 20'h1), memByte(addr & ~20'h1)};
  assign ready = waitCnt == 3'h0;
  always @(posedge clk) begin
    lastBus <= busIn;
    if (ctlPins.ale) begin
      addr <= {ctlPins.upperAddressLines, busOut};
      waitCnt <= waitMax;
    end else if ((strobe || !ctlPins.wrN || ctlPins.cycleTypeStatus == CYC_HALT)
        && waitCnt != 3'h0) begin
      waitCnt <= waitCnt - 3'h1;
    end
  end
endmodule : bsu_mem_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import bsu_pkg::*;
  logic clk, rstn, cpuReset, ready, euReqValid, euDone, qPop, qValid, flushValid, popEn;
  logic instrBoundary, ifFlag, nmi, maskableIrq, irqTake, irqClearIf, haltedOut, resetBusy;
  logic busOen;
  logic [15:0] busIn, busOut, euRdata, flushSeg, flushOff;
  logic [7:0] qByte, irqType, vecType;
  logic [19:0] irqVector, codeAddr;
  logic [2:0] waitMax;
  bsu_ctl_t ctlPins;
  bsu_eureq_t euReq;
  bsu_cyc_t kinds [4] = '{CYC_MEM_READ, CYC_PORT_READ, CYC_MEM_WRITE, CYC_PORT_WRITE};
  int bad_count, samples_checked, takes;
  bsu_bus_unit #(.RESET_CYCLES(2)) u_bsu_bus_unit (.clk(clk), .rstn(rstn),
    .cpuReset(cpuReset), .modeSelectPin(1'b1), .ready(ready), .muxedBusLinesIn(busIn),
    .muxedBusLinesOut(busOut), .muxedBusLinesOen(busOen), .ctlPins(ctlPins),
    .euReqValid(euReqValid), .euReq(euReq), .euDone(euDone), .euRdata(euRdata),
    .qPop(qPop), .qValid(qValid), .qByte(qByte), .flushValid(flushValid),
    .flushSeg(flushSeg), .flushOff(flushOff), .instrBoundary(instrBoundary), .ifFlag(ifFlag),
    .nmi(nmi), .maskableIrq(maskableIrq), .irqTake(irqTake), .irqType(irqType),
    .irqVector(irqVector), .irqClearIf(irqClearIf), .haltedOut(haltedOut),
    .resetBusy(resetBusy));
  bsu_mem_model u_bsu_mem_model (.clk(clk), .ctlPins(ctlPins), .busOut(busOut),
    .busOen(busOen), .waitMax(waitMax), .vecType(vecType), .busIn(busIn), .ready(ready));
  function automatic logic [7:0] memByte(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : memByte
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic cpu_reset;
    int n;
    popEn <= 1'b0;
    cpuReset <= 1'b1;
    repeat (6) @(posedge clk);
    cpuReset <= 1'b0;
    codeAddr <= 20'hFFFF0;
    n = 0;
    while (ctlPins.ale !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    check({ctlPins.upperAddressLines, busOut}, 20'hFFFF0);
    popEn <= 1'b1;
  endtask : cpu_reset
  task automatic eu_op(input bsu_cyc_t k, input logic w);
    bsu_eureq_t r;
    logic [19:0] a;
    int n;
    r = '{k, bsu_seg_t'($urandom % 4), 16'($urandom), 16'($urandom), w, 16'($urandom)};
    a = k[2] ? {r.segBase, 4'h0} + 20'(r.offset) : {4'h0, r.offset};
    waitMax <= 3'($urandom % 4);
    euReq <= r;
    euReqValid <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (euDone !== 1'b1 && n < 100);
    euReqValid <= 1'b0;
    if (k == CYC_MEM_READ || k == CYC_PORT_READ)
      check(w ? 20'(euRdata) : 20'(euRdata[7:0]),
        w ? 20'({memByte(a + 20'h1), memByte(a)}) : 20'(memByte(a)));
    else check(20'(n < 100), 20'h1);
    @(posedge clk);
  endtask : eu_op
  task automatic wait_take(input logic [7:0] expType);
    int n;
    n = 0;
    while (irqTake !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    check(irqVector, {10'h000, expType, 2'b00});
  endtask : wait_take
  task automatic boundary;
    instrBoundary <= 1'b1;
    @(posedge clk);
    instrBoundary <= 1'b0;
  endtask : boundary
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #3000000;
    bad_count++;
    finish_test();
  end
  always @(posedge clk) begin
    if (qPop && qValid) begin
      check(20'(qByte), 20'(memByte(codeAddr)));
      codeAddr <= codeAddr + 20'h1;
    end
    if (irqTake === 1'b1) check(20'(irqClearIf), 20'h1);
    takes += int'(irqTake === 1'b1);
    qPop <= popEn && ($urandom % 2 == 1);
  end
  initial begin
    rstn = 0; cpuReset = 1; euReqValid = 0; euReq = '0; qPop = 0; popEn = 0;
    flushValid = 0; flushSeg = 0; flushOff = 0; instrBoundary = 0; ifFlag = 0;
    nmi = 0; maskableIrq = 0; waitMax = 0; vecType = 0; codeAddr = 20'hFFFF0;
    bad_count = 0; samples_checked = 0; takes = 0;
    void'($urandom(32'hC5CE));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    cpu_reset();
    repeat (40) @(posedge clk);
    $display("test reset and fetch done");
    for (int i = 0; i < 16; i++) eu_op(kinds[i % 4], 1'(i / 4));
    $display("test bus cycles done");
    popEn <= 1'b0;
    repeat (2) @(posedge clk);
    flushSeg <= 16'($urandom);
    flushOff <= 16'($urandom);
    flushValid <= 1'b1;
    @(posedge clk);
    flushValid <= 1'b0;
    codeAddr <= {flushSeg, 4'h0} + 20'(flushOff);
    popEn <= 1'b1;
    repeat (60) @(posedge clk);
    $display("test flush done");
    ifFlag <= 1'b1;
    maskableIrq <= 1'b1;
    nmi <= 1'b1;
    vecType <= 8'($urandom);
    repeat (2) @(posedge clk);
    nmi <= 1'b0;
    boundary();
    wait_take(NMI_TYPE);
    repeat (4) @(posedge clk);
    boundary();
    wait_take(vecType);
    ifFlag <= 1'b0;
    repeat (3) @(posedge clk);
    boundary();
    repeat (30) @(posedge clk);
    ifFlag <= 1'b1;
    repeat (30) @(posedge clk);
    check(20'(takes), 20'h2);
    boundary();
    wait_take(vecType);
    maskableIrq <= 1'b0;
    $display("test interrupts done");
    eu_op(CYC_HALT, 1'b0);
    repeat (3) @(posedge clk);
    check(20'(haltedOut), 20'h1);
    nmi <= 1'b1;
    repeat (2) @(posedge clk);
    nmi <= 1'b0;
    wait_take(NMI_TYPE);
    repeat (3) @(posedge clk);
    check(20'(haltedOut), 20'h0);
    $display("test halt done");
    cpu_reset();
    repeat (20) @(posedge clk);
    for (int i = 0; i < 4; i++) eu_op(kinds[i], 1'b1);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : tb
